/* File: design/function_block_n.sv */
// motion detection function block: sequencing, brightness and telegrams
// Contract
// - three modes: auto on/auto off, manual on/auto off, auto on/manual off.
// - external motion acts like sensor motion; extensions ignore it.
// - manual ON starts a detection, sends start telegrams, starts the delay.
// - manual OFF during detection cancels, stops delay, sends end, goes idle.
// - disable input forces disable action; normal operation resumes on release.
// - manual-start mode ignores motion until manual ON, which starts detection.
// - manual-start detection ends by delay or OFF; then a new ON is needed.
// - manual-end mode starts no delay; only manual OFF ends the detection.
// - manual-end mode is not allowed with the light-control application.
// - two outputs, each configured; no function means no output at all.
// - switching sends one-bit on/off; staircase repeats the on value at intervals.
// - forced position sends two-bit priority values.
// - dimming sends one-byte percent scaled to full range.
// - scene sends one-byte scene numbers one to sixty-four.
// - temperature sends two-byte float, zero to forty degrees, one-degree steps.
// - brightness sends two-byte float lux, zero to 2000, 50-lux steps.
// - controller mode sends one-byte heating mode codes.
// - detector uses only output one as switching; extension has no outputs.
// - three sectors, chosen per block, ORed into one motion signal.
// - brightness is internal, external, or a static weighted mix.
// - without a valid value run brightness-independent; single value unweighted.
// - without motion, presence drops at delay expiry, then end telegrams.
//
// Strobed register access and the register addresses were decided locally.
`timescale 1ns/1ps
module function_block_n
    import mdet_pkg::*;
#(
    parameter int unsigned DELAY_CYCLES = DELAY_CYC,
    parameter int unsigned STAIR_CYCLES = STAIR_CYC
) (
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire fb_cfg_t     cfg_in,
    input  wire logic [2:0]  pir_motion,
    input  wire logic [15:0] int_lux,
    input  wire logic        int_lux_valid,
    input  wire logic [7:0]  addr,
    input  wire logic [31:0] wdata,
    input  wire logic        wr_stb,
    input  wire logic        rd_stb,
    output logic [31:0]      rdata,
    output telegram_t        tg_out,
    output logic             presence
);
    generate
        if (DELAY_CYCLES < 1 || STAIR_CYCLES < 1) begin : g_chk
            $error("delay counts must be at least one cycle");
        end
    endgenerate

    typedef struct packed {
        det_st_t     st;
        fb_cfg_t     cfg;
        logic        cfg_ld;
        logic [31:0] timer;
        logic [31:0] stair;
        logic [1:0]  pend;
        logic [1:0]  pend_on;
        logic        dis;
        logic [15:0] ext_lux;
        logic        ext_valid;
        telegram_t   tg;
        logic [31:0] rdata;
    } fb_state_t;

    fb_state_t s;
    fb_state_t next_s;

    // dpt 9 float from a value in hundredths
    function automatic logic [15:0] to_f16(input logic [31:0] centi);
        logic [31:0] m;
        logic [3:0]  e;
        m = centi;
        e = 4'h0;
        for (int i = 0; i < 15; i++) begin
            if (m > 32'd2047) begin
                m = m >> 1;
                e = e + 4'h1;
            end
        end
        return {1'b0, e, m[10:0]};
    endfunction

    function automatic logic [7:0] clamp(input logic [7:0] v,
                                         input logic [7:0] hi);
        return (v > hi) ? hi : v;
    endfunction

    // value and size of one telegram
    function automatic logic [17:0] encode(input out_fn_t f,
                                           input logic [7:0] sel,
                                           input logic on);
        logic [7:0]  c;
        logic [15:0] pct;
        c   = 8'h00;
        pct = 16'h0000;
        unique case (f)
            FN_SWITCH, FN_STAIRCASE:
                return {2'b00, 15'h0000, on};
            FN_FORCED:
                return {2'b00, 14'h0000, 1'b1, on};
            FN_DIM: begin
                c   = clamp(sel, MAX_PCT);
                pct = (16'(c) * 16'd255 + 16'd50) / 16'd100;
                return {2'b01, 8'h00, pct[7:0]};
            end
            FN_SCENE: begin
                c = clamp(sel, MAX_SCENE);
                c = (c == 8'h00) ? 8'h00 : c - 8'h01;
                return {2'b01, 8'h00, c};
            end
            FN_TEMP: begin
                c = clamp(sel, MAX_TEMP);
                return {2'b10, to_f16(32'(c) * 32'd100)};
            end
            FN_LUX: begin
                c = clamp(sel, MAX_LUXSTEP);
                return {2'b10,
                        to_f16(32'(c) * 32'(LUX_STEP) * 32'd100)};
            end
            FN_HVAC:
                return {2'b01, 8'h00, clamp(sel, MAX_HVAC)};
            default:
                return 18'h00000;
        endcase
    endfunction

    logic [15:0] eff_lux;
    logic        lux_ok;
    logic        dark;
    logic        sens_mot;
    logic        ext_mot;
    logic        motion;
    logic        cmd_wr;
    logic        man_on;
    logic        man_off;
    logic        dis_in;
    logic [19:0] mix;
    logic [17:0] enc;
    out_cfg_t    oc;
    logic        ev_start;
    logic        ev_end;
    logic        ev_disable;

    // weighted mix only when both sources hold a value
    always_comb begin
        mix = 20'(int_lux) * 20'(s.cfg.weight_int)
            + 20'(s.ext_lux) * 20'(WEIGHT_FULL - s.cfg.weight_int);
        unique case (s.cfg.bsrc)
            BSRC_INTERNAL: begin
                eff_lux = int_lux;
                lux_ok  = int_lux_valid;
            end
            BSRC_EXTERNAL: begin
                eff_lux = s.ext_lux;
                lux_ok  = s.ext_valid;
            end
            default: begin
                lux_ok = int_lux_valid | s.ext_valid;
                if (int_lux_valid && s.ext_valid) begin
                    eff_lux = mix[19:4];
                end else if (s.ext_valid) begin
                    eff_lux = s.ext_lux;
                end else begin
                    eff_lux = int_lux;
                end
            end
        endcase
        // no valid value yet: treat as dark, i.e. brightness-independent
        dark = !s.cfg.bright_dep || !lux_ok
            || (eff_lux < s.cfg.dark_level);
    end

    assign cmd_wr   = wr_stb && addr == REG_CMD;
    assign man_on   = cmd_wr && wdata[CMD_ON];
    assign man_off  = cmd_wr && wdata[CMD_OFF] && !wdata[CMD_ON];
    assign dis_in   = cmd_wr ? wdata[CMD_DIS] : s.dis;
    assign sens_mot = |(pir_motion & s.cfg.sectors) && dark;
    assign ext_mot  = cmd_wr && wdata[CMD_EXT]
                   && s.cfg.role != ROLE_EXTENSION
                   && (dark || !s.cfg.ext_bright_dep);
    assign motion   = sens_mot || ext_mot;

    always_comb begin
        next_s     = s;
        ev_start   = 1'b0;
        ev_end     = 1'b0;
        ev_disable = 1'b0;
        enc        = 18'h00000;
        oc         = s.cfg.out0;
        next_s.dis = dis_in;
        if (!s.cfg_ld) begin
            next_s.cfg    = cfg_in;
            next_s.cfg_ld = 1'b1;
            if (cfg_in.mode == MODE_MAN_END
                && cfg_in.app == APP_LIGHT_CTRL) begin
                next_s.cfg.mode = MODE_AUTO;
            end
            if (cfg_in.app == APP_DETECTOR) begin
                next_s.cfg.out0.func = FN_SWITCH;
                next_s.cfg.out1.func = FN_NONE;
                next_s.cfg.bright_dep = 1'b0;
            end
            if (cfg_in.role == ROLE_EXTENSION) begin
                next_s.cfg.out0.func = FN_NONE;
                next_s.cfg.out1.func = FN_NONE;
            end
            next_s.st = (cfg_in.mode == MODE_MAN_START)
                      ? ST_ARM_WAIT : ST_IDLE;
        end else if (dis_in) begin
            if (s.st != ST_DISABLED) begin
                ev_disable = 1'b1;
            end
            next_s.st    = ST_DISABLED;
            next_s.timer = 32'h0;
        end else begin
            unique case (s.st)
                ST_DISABLED: begin
                    next_s.st = (s.cfg.mode == MODE_MAN_START)
                              ? ST_ARM_WAIT : ST_IDLE;
                end
                ST_ARM_WAIT: begin
                    if (man_on) begin
                        ev_start     = 1'b1;
                        next_s.st    = ST_ACTIVE;
                        next_s.timer = DELAY_CYCLES;
                    end
                end
                ST_IDLE: begin
                    if (man_on || motion) begin
                        ev_start     = 1'b1;
                        next_s.st    = ST_ACTIVE;
                        next_s.timer = (s.cfg.mode == MODE_MAN_END)
                                     ? 32'h0 : DELAY_CYCLES;
                    end
                end
                ST_ACTIVE: begin
                    if (man_off) begin
                        ev_end       = 1'b1;
                        next_s.timer = 32'h0;
                    end else if (s.cfg.mode == MODE_MAN_END) begin
                        next_s.timer = 32'h0;
                    end else if (motion || man_on) begin
                        next_s.timer = DELAY_CYCLES;
                    end else if (s.timer <= 32'h1) begin
                        ev_end       = 1'b1;
                        next_s.timer = 32'h0;
                    end else begin
                        next_s.timer = s.timer - 32'h1;
                    end
                    if (ev_end) begin
                        next_s.st = (s.cfg.mode == MODE_MAN_START)
                                  ? ST_ARM_WAIT : ST_IDLE;
                    end
                end
            endcase
        end
        // drain first, so a request raised in the same cycle is kept
        // one telegram per cycle, out0 before out1
        next_s.tg.valid = 1'b0;
        for (int i = 1; i >= 0; i--) begin
            oc = (i == 0) ? s.cfg.out0 : s.cfg.out1;
            if (s.pend[i] && !(i == 1 && s.pend[0])) begin
                enc = encode(oc.func,
                             s.pend_on[i] ? oc.on_sel : oc.off_sel,
                             s.pend_on[i]);
                next_s.tg.valid = 1'b1;
                next_s.tg.chan  = 1'(i);
                next_s.tg.size  = enc[17:16];
                next_s.tg.data  = enc[15:0];
                next_s.pend[i]  = 1'b0;
            end
        end
        // staircase retrigger while presence holds
        if (s.st == ST_ACTIVE && !ev_end && !dis_in) begin
            if (s.stair <= 32'h1) begin
                next_s.stair = STAIR_CYCLES;
                for (int i = 0; i < 2; i++) begin
                    oc = (i == 0) ? s.cfg.out0 : s.cfg.out1;
                    if (oc.func == FN_STAIRCASE) begin
                        next_s.pend[i]    = 1'b1;
                        next_s.pend_on[i] = 1'b1;
                    end
                end
            end else begin
                next_s.stair = s.stair - 32'h1;
            end
        end else begin
            next_s.stair = STAIR_CYCLES;
        end
        if (ev_start || ev_end || ev_disable) begin
            for (int i = 0; i < 2; i++) begin
                oc = (i == 0) ? s.cfg.out0 : s.cfg.out1;
                if (oc.func != FN_NONE) begin
                    next_s.pend[i]    = 1'b1;
                    next_s.pend_on[i] = ev_start
                                     || (ev_disable && s.cfg.dis_on);
                end
            end
        end
        if (wr_stb && addr == REG_EXT_LUX) begin
            next_s.ext_lux   = wdata[15:0];
            next_s.ext_valid = 1'b1;
        end
        next_s.rdata = 32'h0;
        if (rd_stb && addr == REG_STATUS) begin
            next_s.rdata = {eff_lux, 10'h000, int_lux_valid, s.ext_valid,
                            s.dis, s.st == ST_ACTIVE, s.st};
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign rdata    = s.rdata;
    assign tg_out   = s.tg;
    assign presence = s.st == ST_ACTIVE;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    mode_sane_a: assert property (s.cfg_ld |->
        !(s.cfg.mode == MODE_MAN_END && s.cfg.app == APP_LIGHT_CTRL))
        else $error("manual-end mode with light control");
    manual_on_a: assert property (
        s.cfg_ld && s.st == ST_IDLE && man_on && !dis_in
        && s.cfg.mode == MODE_AUTO
        |=> s.st == ST_ACTIVE && s.timer == DELAY_CYCLES)
        else $error("manual on did not start detection");
    manual_off_a: assert property (
        s.cfg_ld && s.st == ST_ACTIVE && man_off && !dis_in
        |=> s.st inside {ST_IDLE, ST_ARM_WAIT} && s.timer == 32'h0)
        else $error("manual off did not end detection");
    ext_block_a: assert property (
        s.cfg_ld && s.cfg.role == ROLE_EXTENSION && s.st == ST_IDLE
        && !man_on && !dis_in && !(|(pir_motion & s.cfg.sectors))
        |=> s.st == ST_IDLE)
        else $error("extension accepted external motion");
    disable_hold_a: assert property (s.cfg_ld && dis_in
        |=> s.st == ST_DISABLED)
        else $error("disable not forced");
    arm_wait_a: assert property (
        s.cfg_ld && s.st == ST_ARM_WAIT && !man_on && !dis_in
        |=> s.st == ST_ARM_WAIT)
        else $error("motion accepted before manual on");
    no_delay_a: assert property (
        s.st == ST_ACTIVE && s.cfg.mode == MODE_MAN_END
        |-> s.timer == 32'h0)
        else $error("delay running in manual-end mode");
    expire_end_a: assert property (
        s.st == ST_ACTIVE && s.timer == 32'h1 && !motion && !man_on
        && !man_off && !dis_in && s.cfg.mode != MODE_MAN_END
        && (s.cfg.out0.func != FN_NONE || s.cfg.out1.func != FN_NONE)
        |=> !presence ##[1:3] tg_out.valid)
        else $error("expiry did not end presence");
    det_out_a: assert property (
        tg_out.valid && s.cfg.app == APP_DETECTOR
        |-> tg_out.chan == 1'b0 && tg_out.data[15:1] == 15'h0)
        else $error("detector used a second or wide output");
    ext_none_a: assert property (
        s.cfg.role == ROLE_EXTENSION |-> !tg_out.valid)
        else $error("extension sent a telegram");

    start_c: cover property (s.st == ST_IDLE ##1 s.st == ST_ACTIVE);
    expire_c: cover property (presence ##1 !presence);
    disable_c: cover property (s.st == ST_DISABLED ##1
                               s.st != ST_DISABLED);
endmodule

/* File: design/mdet_pkg.sv */
// shared types and constants of the motion detection function block
package mdet_pkg;
    localparam int unsigned CLK_HZ      = 100_000_000;
    localparam int unsigned DELAY_S     = 10;
    // kept under 43 s so the cycle count still fits a 32-bit counter
    localparam int unsigned STAIR_S     = 40;
    localparam int unsigned DELAY_CYC   = DELAY_S * CLK_HZ;
    localparam int unsigned STAIR_CYC   = STAIR_S * CLK_HZ;
    localparam logic [7:0]  REG_CMD     = 8'h00;
    localparam logic [7:0]  REG_EXT_LUX = 8'h04;
    localparam logic [7:0]  REG_STATUS  = 8'h08;
    localparam int unsigned CMD_ON      = 0;
    localparam int unsigned CMD_OFF     = 1;
    localparam int unsigned CMD_EXT     = 2;
    localparam int unsigned CMD_DIS     = 3;
    localparam logic [7:0]  MAX_PCT     = 8'h64;
    localparam logic [7:0]  MAX_SCENE   = 8'h40;
    localparam logic [7:0]  MAX_TEMP    = 8'h28;
    localparam logic [7:0]  MAX_LUXSTEP = 8'h28;
    localparam logic [7:0]  MAX_HVAC    = 8'h04;
    localparam logic [7:0]  LUX_STEP    = 8'h32;
    localparam logic [4:0]  WEIGHT_FULL = 5'h10;

    typedef enum logic [1:0] {
        MODE_AUTO       = 2'b00,
        MODE_MAN_START  = 2'b01,
        MODE_MAN_END    = 2'b10
    } op_mode_t;

    typedef enum logic [1:0] {
        APP_DETECTOR    = 2'b00,
        APP_CEILING     = 2'b01,
        APP_PRESENCE    = 2'b10,
        APP_LIGHT_CTRL  = 2'b11
    } app_t;

    typedef enum logic [1:0] {
        ROLE_SINGLE     = 2'b00,
        ROLE_MAIN       = 2'b01,
        ROLE_EXTENSION  = 2'b10
    } role_t;

    typedef enum logic [1:0] {
        BSRC_INTERNAL   = 2'b00,
        BSRC_EXTERNAL   = 2'b01,
        BSRC_MIXED      = 2'b10
    } bsrc_t;

    typedef enum logic [3:0] {
        FN_NONE         = 4'h0,
        FN_SWITCH       = 4'h1,
        FN_STAIRCASE    = 4'h2,
        FN_FORCED       = 4'h3,
        FN_DIM          = 4'h4,
        FN_SCENE        = 4'h5,
        FN_TEMP         = 4'h6,
        FN_LUX          = 4'h7,
        FN_HVAC         = 4'h8
    } out_fn_t;

    typedef enum logic [1:0] {
        ST_IDLE         = 2'b00,
        ST_ARM_WAIT     = 2'b01,
        ST_ACTIVE       = 2'b10,
        ST_DISABLED     = 2'b11
    } det_st_t;

    typedef struct packed {
        out_fn_t    func;
        logic [7:0] on_sel;
        logic [7:0] off_sel;
    } out_cfg_t;

    typedef struct packed {
        op_mode_t    mode;
        app_t        app;
        role_t       role;
        logic [2:0]  sectors;
        bsrc_t       bsrc;
        logic [4:0]  weight_int;
        logic        bright_dep;
        logic        ext_bright_dep;
        logic [15:0] dark_level;
        logic        dis_on;
        out_cfg_t    out0;
        out_cfg_t    out1;
    } fb_cfg_t;

    typedef struct packed {
        logic        valid;
        logic        chan;
        logic [1:0]  size;
        logic [15:0] data;
    } telegram_t;
endpackage

/* File: testbench/actuator_model.sv */
// actuator side of the bus: logs every telegram the block sends
`timescale 1ns/1ps
module actuator_model
    import mdet_pkg::*;
(
    input wire logic      mclk,
    input wire telegram_t tg_in
);
    telegram_t log_q[$];

    // a telegram stands one cycle only, so it is caught at that edge
    always @(posedge mclk) begin
        if (tg_in.valid === 1'b1) begin
            log_q.push_back(tg_in);
        end
    end
endmodule

/* File: testbench/function_block_n_test.sv */
// self-checking bench of the motion detection function block
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin \
    comparisons++; \
    if ((got) !== (exp)) begin \
        mismatches++; \
        $display("[ERR] %s expected %0h seen %0h", nm, exp, got); \
    end \
end
module function_block_n_test
    import mdet_pkg::*;
;
    // short counts keep the run small; expectations use the same values
    localparam int unsigned DLY = 20;
    localparam int unsigned STR = 7;
    logic        mclk;
    logic        rst;
    fb_cfg_t     cfg;
    logic [2:0]  pir_motion;
    logic [15:0] int_lux;
    logic        int_lux_valid;
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr_stb;
    logic        rd_stb;
    logic [31:0] rdata;
    telegram_t   tg_out;
    logic        presence;
    int          mismatches = 0;
    int          comparisons = 0;
    out_fn_t     fns[5] = '{FN_FORCED, FN_SCENE, FN_TEMP, FN_LUX, FN_HVAC};
    logic [7:0]  sels[5] = '{8'h01, 8'h40, 8'h14, 8'h02, 8'h07};
    logic [1:0]  szs[5] = '{2'h0, 2'h1, 2'h2, 2'h2, 2'h1};
    logic [15:0] ons[5] = '{16'h3, 16'h3f, 16'h07d0, 16'h1ce2, 16'h4};
    logic [15:0] offs[5] = '{16'h2, 16'h0, 16'h0, 16'h0, 16'h0};

    function_block_n #(.DELAY_CYCLES(DLY), .STAIR_CYCLES(STR))
    function_block_n_i (
        .mclk(mclk), .rst(rst), .cfg_in(cfg), .pir_motion(pir_motion),
        .int_lux(int_lux), .int_lux_valid(int_lux_valid), .addr(addr),
        .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
        .tg_out(tg_out), .presence(presence)
    );
    actuator_model actuator_model_i (.mclk(mclk), .tg_in(tg_out));

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // config is only taken after reset, so each scenario resets anew
    task automatic start(input fb_cfg_t c, input int n);
        @(posedge mclk);
        rst <= 1'b1;
        cfg <= c;
        pir_motion <= 3'h0;
        repeat (n) @(posedge mclk);
        rst <= 1'b0;
        repeat (2) @(posedge mclk);
        actuator_model_i.log_q.delete();
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'b1;
        @(posedge mclk);
        wr_stb <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge mclk);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge mclk);
        rd_stb <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic pir(input logic [2:0] m);
        @(posedge mclk);
        pir_motion <= m;
    endtask
    task automatic wait_pres(input logic v, input int lim);
        int k;
        k = 0;
        while (presence !== v && k < lim) begin
            idle(1);
            k++;
        end
        `CHK("presence", v, presence)
    endtask
    task automatic tg(input string nm, input logic ch, input logic [1:0] sz,
                      input logic [15:0] dt);
        telegram_t t;
        t = '0;
        if (actuator_model_i.log_q.size() > 0)
            t = actuator_model_i.log_q.pop_front();
        `CHK(nm, {1'b1, ch, sz, dt}, t)
    endtask
    task automatic quiet();
        `CHK("extra telegrams", 0, actuator_model_i.log_q.size())
    endtask

    initial begin
        fb_cfg_t     base;
        fb_cfg_t     c;
        logic [31:0] s;
        {addr, wdata, wr_stb, rd_stb, int_lux, int_lux_valid} = '0;
        pir_motion = 3'h0;
        rst = 1'b1;
        base = '0;
        base.app = APP_CEILING;
        base.sectors = 3'b010;
        base.weight_int = 5'h08;
        base.dis_on = 1'b1;
        base.out0.func = FN_SWITCH;
        base.out1.func = FN_DIM;
        base.out1.on_sel = MAX_PCT;
        cfg = base;
        start(base, 6);
        pir(3'b101);
        idle(6);
        `CHK("unassigned", 1'b0, presence)
        pir(3'b010);
        wait_pres(1'b1, 5);
        idle(3);
        tg("on switch", 1'b0, 2'h0, 16'h1);
        tg("on dim", 1'b1, 2'h1, 16'h00ff);
        pir(3'h0);
        idle(DLY - 5);
        `CHK("held", 1'b1, presence)
        wait_pres(1'b0, 15);
        idle(3);
        tg("off switch", 1'b0, 2'h0, 16'h0);
        tg("off dim", 1'b1, 2'h1, 16'h0);
        wr(REG_CMD, 32'h1);
        wait_pres(1'b1, 4);
        idle(3);
        tg("man on sw", 1'b0, 2'h0, 16'h1);
        tg("man on dim", 1'b1, 2'h1, 16'h00ff);
        wr(REG_CMD, 32'h2);
        wait_pres(1'b0, 4);
        idle(3);
        tg("man off sw", 1'b0, 2'h0, 16'h0);
        tg("man off dim", 1'b1, 2'h1, 16'h0);
        idle(DLY + 5);
        quiet();
        $display("test auto and manual done");
        c = base;
        c.mode = MODE_MAN_START;
        start(c, 2);
        pir(3'b010);
        idle(8);
        `CHK("armed", 1'b0, presence)
        wr(REG_CMD, 32'h1);
        wait_pres(1'b1, 4);
        pir(3'h0);
        wait_pres(1'b0, DLY + 10);
        pir(3'b010);
        idle(8);
        rd(REG_STATUS, s);
        `CHK("rearm state", 2'h1, s[1:0])
        wr(REG_CMD, 32'h1);
        wait_pres(1'b1, 4);
        wr(REG_CMD, 32'h2);
        wait_pres(1'b0, 4);
        idle(8);
        `CHK("needs on", 1'b0, presence)
        $display("test manual start done");
        c.mode = MODE_MAN_END;
        start(c, 2);
        pir(3'b010);
        wait_pres(1'b1, 5);
        pir(3'h0);
        idle(DLY * 3);
        `CHK("no delay", 1'b1, presence)
        wr(REG_CMD, 32'h2);
        wait_pres(1'b0, 4);
        pir(3'b010);
        wait_pres(1'b1, 5);
        c.app = APP_LIGHT_CTRL;
        start(c, 2);
        pir(3'b010);
        wait_pres(1'b1, 5);
        pir(3'h0);
        wait_pres(1'b0, DLY + 10);
        $display("test manual end done");
        start(base, 2);
        wr(REG_CMD, 32'h8);
        idle(4);
        rd(REG_STATUS, s);
        `CHK("disabled", 2'h3, s[1:0])
        tg("dis sw", 1'b0, 2'h0, 16'h1);
        tg("dis dim", 1'b1, 2'h1, 16'h00ff);
        wr(REG_CMD, 32'hc);
        pir(3'b010);
        idle(6);
        `CHK("dis motion", 1'b0, presence)
        pir(3'h0);
        wr(REG_CMD, 32'h0);
        rd(REG_STATUS, s);
        `CHK("released", 2'h0, s[1:0])
        wr(REG_CMD, 32'h4);
        wait_pres(1'b1, 4);
        c = base;
        c.role = ROLE_EXTENSION;
        start(c, 2);
        wr(REG_CMD, 32'h4);
        idle(6);
        `CHK("ext ignored", 1'b0, presence)
        pir(3'b010);
        wait_pres(1'b1, 5);
        idle(4);
        quiet();
        c = base;
        c.app = APP_DETECTOR;
        start(c, 2);
        wr(REG_CMD, 32'h1);
        idle(4);
        tg("detector", 1'b0, 2'h0, 16'h1);
        quiet();
        $display("test disable and roles done");
        for (int i = 0; i < 5; i++) begin
            c = base;
            c.out0.func = fns[i];
            c.out0.on_sel = sels[i];
            c.out1.func = FN_NONE;
            start(c, 2);
            wr(REG_CMD, 32'h1);
            idle(4);
            tg("fn on", 1'b0, szs[i], ons[i]);
            wr(REG_CMD, 32'h2);
            idle(4);
            tg("off code", 1'b0, szs[i], offs[i]);
            quiet();
        end
        c.out0.func = FN_STAIRCASE;
        start(c, 2);
        pir(3'b010);
        idle(4 * STR);
        `CHK("repeats", 1'b1, actuator_model_i.log_q.size() >= 3)
        $display("test output codes done");
        c = base;
        c.bsrc = BSRC_EXTERNAL;
        c.bright_dep = 1'b1;
        c.dark_level = 16'h0064;
        start(c, 2);
        pir(3'b010);
        wait_pres(1'b1, 5);
        pir(3'h0);
        wr(REG_CMD, 32'h2);
        wr(REG_EXT_LUX, 32'h1f4);
        pir(3'b010);
        idle(8);
        `CHK("bright", 1'b0, presence)
        pir(3'h0);
        wr(REG_EXT_LUX, 32'h32);
        pir(3'b010);
        wait_pres(1'b1, 5);
        c.bsrc = BSRC_MIXED;
        start(c, 2);
        int_lux <= 16'h00c8;
        wr(REG_EXT_LUX, 32'h190);
        rd(REG_STATUS, s);
        `CHK("one source", 16'h0190, s[31:16])
        @(posedge mclk) int_lux_valid <= 1'b1;
        idle(3);
        rd(REG_STATUS, s);
        `CHK("weighted", 16'h012c, s[31:16])
        $display("test brightness done");
        conclude();
    end

    // the scenarios need well under a thousand cycles; this is far beyond them
    initial begin
        repeat (50000) @(posedge mclk);
        mismatches++;
        conclude();
    end
endmodule
